// [fmt_regs_pkg.sv]
package fmt_regs_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [10:0] IDX_PAT3_LO   = 11'h555;
  localparam logic [10:0] IDX_PAT3_HI   = 11'h556;
  localparam logic [10:0] IDX_PAT4_LO   = 11'h557;
  localparam logic [10:0] IDX_PAT4_HI   = 11'h558;
  localparam logic [10:0] IDX_STSEL     = 11'h559;
  localparam logic [10:0] IDX_FORMAT    = 11'h561;
  localparam logic [10:0] IDX_OR_CLEAR  = 11'h562;
  localparam logic [10:0] IDX_OR_STATUS = 11'h563;
  localparam logic [10:0] IDX_CHAN_SEL  = 11'h564;
  localparam logic [10:0] IDX_IRQ_STAT  = 11'h565;
  localparam logic [10:0] IDX_IRQ_MASK  = 11'h566;

  // Reset values.
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_FORMAT = 8'h01;

  // Field positions.
  localparam int STSEL_LSB  = 0;
  localparam int FMT_LSB    = 0;
  localparam int INVERT_BIT = 2;
  localparam int SWAP_BIT   = 0;

  // Status bit selector codes.
  localparam logic [2:0] STSEL_TIE_LOW   = 3'h0;
  localparam logic [2:0] STSEL_OVERRANGE = 3'h1;
  localparam logic [2:0] STSEL_SIG_MON   = 3'h2;
  localparam logic [2:0] STSEL_FAST_DET  = 3'h3;
  localparam logic [2:0] STSEL_VAR_RANGE = 3'h4;

  // Number format codes.
  localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
  localparam logic [1:0] FMT_TWOS_COMP  = 2'h1;

  // Test mode selector code for the user pattern.
  localparam logic [3:0] TEST_USER_PATTERN = 4'h8;

  // Index of the last user pattern word; one sequence has four words.
  localparam logic [1:0] PAT_LAST_IDX = 2'h3;

endpackage : fmt_regs_pkg

// [sample_formatter.sv]
// Formats one converter sample and appends the selected status bit.
// Incoming samples are two's complement.
module sample_formatter
  import fmt_regs_pkg::*;
#(
  parameter int SAMPLE_W = 14
) (
  // Sample in.
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire logic                overrange,
  input  wire logic                sig_mon,
  input  wire logic                fast_level_detect,
  input  wire logic                variable_range_monitor,
  // Settings.
  input  wire logic [1:0]          fmt,
  input  wire logic                invert,
  input  wire logic [2:0]          stsel,
  // Word out.
  output logic      [SAMPLE_W:0]   word
);

  logic [SAMPLE_W-1:0] coded;  // Sample after format and inversion.
  logic                stbit;  // Selected status bit.

  // Offset binary flips the sign bit; undefined codes stay two's complement.
  always_comb begin
    coded = sample;
    if (fmt == FMT_OFFSET_BIN) begin
      coded[SAMPLE_W-1] = ~sample[SAMPLE_W-1];
    end
    if (invert) begin
      coded = ~coded;
    end
  end

  // Unused selector codes tie the bit low so nothing stale leaks out.
  always_comb begin
    unique case (stsel)
      STSEL_TIE_LOW:   stbit = 1'b0;
      STSEL_OVERRANGE: stbit = overrange;
      STSEL_SIG_MON:   stbit = sig_mon;
      STSEL_FAST_DET:  stbit = fast_level_detect;
      STSEL_VAR_RANGE: stbit = variable_range_monitor;
      default:         stbit = 1'b0;
    endcase
  end

  assign word = {stbit, coded};

endmodule : sample_formatter

// [range_flags.sv]
// Sticky range-exceed flags, one per virtual converter.
module range_flags #(
  parameter int NUM_VC = 8
) (
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Events and clear controls.
  input  wire logic [NUM_VC-1:0] evt,
  input  wire logic [NUM_VC-1:0] clear,
  // Flags.
  output logic      [NUM_VC-1:0] flags
);

  typedef struct packed {
    logic [NUM_VC-1:0] flag;
  } rf_state_t;

  rf_state_t st_r;   // Registered state.
  rf_state_t st_nxt; // Next state.

  // A new event wins over a clear held in the same cycle, so none is lost.
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < NUM_VC; i++) begin
      st_nxt.flag[i] = evt[i] | (st_r.flag[i] & ~clear[i]);
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flag;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flag_holds_set: assert property (
    (|st_r.flag) && !(|clear) |=> ((flags & $past(flags)) == $past(flags)))
    else $error("range flag dropped without a clear");

endmodule : range_flags

// [fmt_status_regs.sv]
// Functional notes
// - Status bit chosen by 3-bit selector.
// - Offset binary or two's complement; optional inversion.
// - Clear bit at one clears converter flag.
// - Read-only bit per converter shows range exceed.
// - Swap bit exchanges output channel order.
// - User pattern repeats, or runs once.
//
// Local design decision: the APB slave port.
module fmt_status_regs
  import fmt_regs_pkg::*;
#(
  parameter int SAMPLE_W = 14,
  parameter int NUM_VC   = 8,
  parameter int ADDR_W   = 13
) (
  // Clock and reset.
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave.
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Test mode settings held in neighbouring registers.
  input  wire logic [3:0]          test_mode_sel,
  input  wire logic                pattern_single,
  input  wire logic [15:0]         pattern_word1,
  input  wire logic [15:0]         pattern_word2,
  // Converter samples in.
  input  wire logic                in_valid,
  input  wire logic [SAMPLE_W-1:0] ch_a_sample,
  input  wire logic [SAMPLE_W-1:0] ch_b_sample,
  input  wire logic [1:0]          overrange,
  input  wire logic [1:0]          sig_mon,
  input  wire logic [1:0]          fast_level_detect,
  input  wire logic [1:0]          variable_range_monitor,
  // Range exceed events per virtual converter.
  input  wire logic [NUM_VC-1:0]   range_evt,
  // Formatted samples out.
  output logic                     out_valid,
  output logic      [SAMPLE_W:0]   out_a,
  output logic      [SAMPLE_W:0]   out_b,
  // Interrupt.
  output logic                     irq
);

  // One-hot states of the user pattern sequencer.
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_RUN  = 3'b010,
    SEQ_DONE = 3'b100
  } seq_t;

  typedef struct packed {
    logic [7:0]          pat3_lo;  // Pattern word 3, low byte.
    logic [7:0]          pat3_hi;  // Pattern word 3, high byte.
    logic [7:0]          pat4_lo;  // Pattern word 4, low byte.
    logic [7:0]          pat4_hi;  // Pattern word 4, high byte.
    logic [7:0]          stsel;    // Status bit selector.
    logic [7:0]          fmt;      // Number format and invert.
    logic [7:0]          orclr;    // Range flag clear controls.
    logic [7:0]          chsel;    // Channel order.
    logic [7:0]          irq_stat; // Sticky interrupt status.
    logic [7:0]          irq_mask; // Interrupt mask.
    logic [31:0]         rdata;    // Read data for the access phase.
    logic                hit;      // Address of current transfer mapped.
    seq_t                seq;      // Pattern sequencer state.
    logic [1:0]          pat_idx;  // Next pattern word.
    logic                ovalid;   // Output sample valid.
    logic [SAMPLE_W:0]   oa;       // Output channel A word.
    logic [SAMPLE_W:0]   ob;       // Output channel B word.
  } regs_t;

  regs_t st_r;   // Registered state.
  regs_t st_nxt; // Next state.

  logic [NUM_VC-1:0]   flags;     // Sticky range exceed flags.
  logic [SAMPLE_W:0]   fmt_w [2]; // Formatted words per channel.
  logic [SAMPLE_W-1:0] smp [2];   // Raw samples per channel.
  logic [10:0]         idx;       // Word index of the bus address.
  logic                mapped;    // Address decodes to a register.
  logic                setup;     // Setup phase of a transfer.
  logic                wr_acc;    // Completing write.
  logic                user_mode; // User pattern test mode active.
  logic [15:0]         pat_word;  // Pattern word for this sample.
  logic [7:0]          rd_byte;   // Selected register byte.

  assign smp[0] = ch_a_sample;
  assign smp[1] = ch_b_sample;

  // One formatter per converter channel.
  for (genvar c = 0; c < 2; c++) begin : g_fmt
    sample_formatter #(
      .SAMPLE_W (SAMPLE_W)
    ) u_fmt (
      .sample                 (smp[c]),
      .overrange              (overrange[c]),
      .sig_mon                (sig_mon[c]),
      .fast_level_detect      (fast_level_detect[c]),
      .variable_range_monitor (variable_range_monitor[c]),
      .fmt                    (st_r.fmt[FMT_LSB+:2]),
      .invert                 (st_r.fmt[INVERT_BIT]),
      .stsel                  (st_r.stsel[STSEL_LSB+:3]),
      .word                   (fmt_w[c])
    );
  end

  // Sticky range flags with their clear controls.
  range_flags #(
    .NUM_VC (NUM_VC)
  ) u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .evt     (range_evt),
    .clear   (st_r.orclr[NUM_VC-1:0]),
    .flags   (flags)
  );

  // Bus decode; the low two address bits select nothing.
  assign idx       = paddr[ADDR_W-1:2];
  assign setup     = psel && !penable;
  assign wr_acc    = psel && penable && pwrite && st_r.hit;
  assign user_mode = (test_mode_sel == TEST_USER_PATTERN);

  // Register read mux; unmapped indices read as zero.
  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    unique case (idx)
      IDX_PAT3_LO:   rd_byte = st_r.pat3_lo;
      IDX_PAT3_HI:   rd_byte = st_r.pat3_hi;
      IDX_PAT4_LO:   rd_byte = st_r.pat4_lo;
      IDX_PAT4_HI:   rd_byte = st_r.pat4_hi;
      IDX_STSEL:     rd_byte = st_r.stsel;
      IDX_FORMAT:    rd_byte = st_r.fmt;
      IDX_OR_CLEAR:  rd_byte = st_r.orclr;
      IDX_OR_STATUS: rd_byte = flags;
      IDX_CHAN_SEL:  rd_byte = st_r.chsel;
      IDX_IRQ_STAT:  rd_byte = st_r.irq_stat;
      IDX_IRQ_MASK:  rd_byte = st_r.irq_mask;
      default:       mapped  = 1'b0;
    endcase
  end

  // Pattern word for the sample slot; words 3 and 4 come from bytes here.
  always_comb begin
    unique case (st_r.pat_idx)
      2'h0:    pat_word = pattern_word1;
      2'h1:    pat_word = pattern_word2;
      2'h2:    pat_word = {st_r.pat3_hi, st_r.pat3_lo};
      default: pat_word = {st_r.pat4_hi, st_r.pat4_lo};
    endcase
  end

  // Next-state logic for registers, sequencer and sample output.
  always_comb begin
    st_nxt = st_r;
    // Read data is captured in setup so the access phase needs no wait.
    if (setup) begin
      st_nxt.hit   = mapped;
      st_nxt.rdata = {24'h000000, rd_byte};
    end
    // Writes take effect at the completing edge; read-only bits ignore them.
    if (wr_acc) begin
      unique case (idx)
        IDX_PAT3_LO:  st_nxt.pat3_lo  = pwdata[7:0];
        IDX_PAT3_HI:  st_nxt.pat3_hi  = pwdata[7:0];
        IDX_PAT4_LO:  st_nxt.pat4_lo  = pwdata[7:0];
        IDX_PAT4_HI:  st_nxt.pat4_hi  = pwdata[7:0];
        IDX_STSEL:    st_nxt.stsel    = {5'h00, pwdata[2:0]};
        IDX_FORMAT:   st_nxt.fmt      = {5'h00, pwdata[2:0]};
        IDX_OR_CLEAR: st_nxt.orclr    = pwdata[7:0];
        IDX_CHAN_SEL: st_nxt.chsel    = {7'h00, pwdata[0]};
        IDX_IRQ_MASK: st_nxt.irq_mask = pwdata[7:0];
        default:      st_nxt.hit      = st_r.hit;
      endcase
    end
    // Events set interrupt status; the set wins over a one written to clear.
    if (wr_acc && idx == IDX_IRQ_STAT) begin
      st_nxt.irq_stat = st_r.irq_stat & ~pwdata[7:0];
    end
    st_nxt.irq_stat = st_nxt.irq_stat | range_evt;
    // Sequencer leaves any test state as soon as the mode is dropped.
    if (!user_mode) begin
      st_nxt.seq     = SEQ_IDLE;
      st_nxt.pat_idx = 2'h0;
    end else begin
      unique case (st_r.seq)
        SEQ_IDLE: begin
          st_nxt.seq     = SEQ_RUN;
          st_nxt.pat_idx = 2'h0;
        end
        SEQ_RUN: begin
          if (in_valid) begin
            st_nxt.pat_idx = st_r.pat_idx + 2'h1;
            if (pattern_single && st_r.pat_idx == PAT_LAST_IDX) begin
              st_nxt.seq = SEQ_DONE;
            end
          end
        end
        SEQ_DONE: begin
          st_nxt.seq = SEQ_DONE;
        end
      endcase
    end
    // Output words; a single pattern is followed by zero words.
    st_nxt.ovalid = in_valid;
    if (in_valid) begin
      if (user_mode) begin
        if (st_r.seq == SEQ_RUN) begin
          st_nxt.oa = {1'b0, pat_word[SAMPLE_W-1:0]};
          st_nxt.ob = {1'b0, pat_word[SAMPLE_W-1:0]};
        end else begin
          st_nxt.oa = '0;
          st_nxt.ob = '0;
        end
      end else if (st_r.chsel[SWAP_BIT]) begin
        st_nxt.oa = fmt_w[1];
        st_nxt.ob = fmt_w[0];
      end else begin
        st_nxt.oa = fmt_w[0];
        st_nxt.ob = fmt_w[1];
      end
    end
  end

  // State register; reset values match the register defaults.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.fmt      <= RST_FORMAT;
      st_r.stsel    <= RST_ZERO;
      st_r.seq      <= SEQ_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Zero wait states; unmapped addresses answer with an error.
  assign pready    = psel && penable;
  assign pslverr   = psel && penable && !st_r.hit;
  assign prdata    = st_r.rdata;
  assign out_valid = st_r.ovalid;
  assign out_a     = st_r.oa;
  assign out_b     = st_r.ob;
  assign irq       = |(st_r.irq_stat & st_r.irq_mask);

  // Helpers read only by the checks below.
  logic [NUM_VC-1:0] clr_only;
  logic              a_msb;
  assign clr_only = st_r.orclr[NUM_VC-1:0] & ~range_evt;
  assign a_msb    = ch_a_sample[SAMPLE_W-1];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_plain_sample;
    in_valid && !user_mode && !st_r.chsel[SWAP_BIT];
  endsequence

  sequence s_run_last;
    in_valid && user_mode && pattern_single && st_r.seq == SEQ_RUN
      && st_r.pat_idx == PAT_LAST_IDX;
  endsequence

  a_flag_sets: assert property (
    (|range_evt) |=> ((flags & $past(range_evt)) == $past(range_evt)))
    else $error("range event did not set its flag");

  a_flag_clears: assert property (
    (|clr_only) |=> ((flags & $past(clr_only)) == '0))
    else $error("clear control did not clear flag");

  a_swap_order: assert property (
    in_valid && !user_mode && st_r.chsel[SWAP_BIT]
      |=> out_a == $past(fmt_w[1]) && out_b == $past(fmt_w[0]))
    else $error("channel swap not applied");

  a_offset_sign: assert property (
    s_plain_sample ##0 (st_r.fmt[2:0] == 3'h0)
      |=> out_a[SAMPLE_W-1] == !$past(a_msb))
    else $error("offset binary sign bit wrong");

  a_twos_sign: assert property (
    s_plain_sample ##0 (st_r.fmt[2:0] == 3'h1)
      |=> out_a[SAMPLE_W-1] == $past(a_msb))
    else $error("two's complement sign bit wrong");

  a_status_tie: assert property (
    in_valid && !user_mode && st_r.stsel[2:0] == STSEL_TIE_LOW
      |=> !out_a[SAMPLE_W] && !out_b[SAMPLE_W])
    else $error("status bit not tied low");

  a_status_vrm: assert property (
    s_plain_sample ##0 (st_r.stsel[2:0] == STSEL_VAR_RANGE)
      |=> out_a[SAMPLE_W] == $past(variable_range_monitor[0]))
    else $error("range monitor bit not selected");

  a_single_stop: assert property (
    s_run_last ##1 (user_mode && in_valid)[*2]
      |=> out_a == '0 && out_b == '0)
    else $error("single pattern did not stop");

  a_irq_raise: assert property (
    (|(range_evt & st_r.irq_mask)) |=> irq)
    else $error("unmasked event did not raise interrupt");

endmodule : fmt_status_regs

// [sample_sink.sv]
// Downstream logic that captures every formatted sample pair.
module sample_sink #(
  parameter int W = 15
) (
  // Clock.
  input wire logic         pclk,
  // Formatted samples in.
  input wire logic         out_valid,
  input wire logic [W-1:0] out_a,
  input wire logic [W-1:0] out_b
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [W-1:0] qa[$];  // Captured channel A words, oldest first.
  logic [W-1:0] qb[$];  // Captured channel B words, oldest first.

  // Capture on each valid cycle; no back-pressure exists, so never stall.
  always @(posedge pclk) begin
    if (out_valid === 1'b1) begin
      qa.push_back(out_a);
      qb.push_back(out_b);
    end
  end
endmodule : sample_sink

// [fmt_status_regs_tb.sv]
// Self-checking bench for the output format and status register bank.
module fmt_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fmt_regs_pkg::*;

  logic        pclk = 0, presetn = 0;      // Clock and reset.
  logic        psel = 0, penable = 0;      // Bus controls.
  logic        pwrite = 0;                 // Bus direction.
  logic [12:0] paddr = 0;                  // Byte address.
  logic [31:0] pwdata = 0, prdata;         // Bus data.
  logic        pready, pslverr;            // Bus answer.
  logic [3:0]  test_mode_sel = 0;          // Test mode selector.
  logic        pattern_single = 0;         // One-shot pattern mode.
  logic [15:0] pw1 = 16'hd111, pw2 = 16'h2222;  // Upper bits must drop.
  logic        in_valid = 0;               // Sample valid.
  logic [13:0] ch_a = 0, ch_b = 0;         // Raw samples.
  logic [1:0]  ovr = 0, smon = 0;          // Status sources.
  logic [1:0]  fld = 0, vrm = 0;           // Status sources.
  logic [7:0]  range_evt = 0;              // Range exceed events.
  logic        out_valid, irq;             // Stream valid, interrupt.
  logic [14:0] out_a, out_b;               // Formatted words.
  int          err_total = 0, n_compared = 0;  // Tallies.
  logic [31:0] r;                          // Scratch read data.
  logic        e;                          // Scratch error flag.

  // Free-running 100 MHz clock.
  always #5 pclk = ~pclk;

  fmt_status_regs u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .test_mode_sel(test_mode_sel),
    .pattern_single(pattern_single), .pattern_word1(pw1),
    .pattern_word2(pw2), .in_valid(in_valid), .ch_a_sample(ch_a),
    .ch_b_sample(ch_b), .overrange(ovr), .sig_mon(smon),
    .fast_level_detect(fld), .variable_range_monitor(vrm),
    .range_evt(range_evt), .out_valid(out_valid), .out_a(out_a),
    .out_b(out_b), .irq(irq)
  );

  sample_sink u_sink (
    .pclk(pclk), .out_valid(out_valid), .out_a(out_a), .out_b(out_b)
  );

  // Prints the tallies and the verdict, then stops the run.
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // One bus transfer; waits for pready as long as it takes.
  // Only the watchdog ends a wait, so a dead slave still ends the run.
  task automatic apb(input logic wr, input logic [10:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Write that must be accepted.
  task automatic wr(input logic [10:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d}, r, e);
    chk("pslverr", 0, e);
  endtask : wr

  // Read compared with an expected value.
  task automatic rdc(input string nm, input logic [10:0] idx,
                     input logic [31:0] ex);
    apb(1'b0, idx, 32'h0, r, e);
    chk(nm, ex, r);
  endtask : rdc

  // Sends one sample pair; the result lands one edge later.
  // It is judged at the edge after that, where it has settled.
  task automatic smp(input logic [13:0] a, input logic [13:0] b,
                     input logic [14:0] ea, input logic [14:0] eb);
    @(posedge pclk);
    in_valid <= 1'b1;
    ch_a     <= a;
    ch_b     <= b;
    @(posedge pclk);
    in_valid <= 1'b0;
    @(posedge pclk);
    chk("out_valid", 1, out_valid);
    chk("out_a", {17'h0, ea}, {17'h0, out_a});
    chk("out_b", {17'h0, eb}, {17'h0, out_b});
  endtask : smp

  // Expected word for a two's complement sample, status bit low.
  function automatic logic [14:0] fx(input logic [13:0] s,
                                     input logic [2:0] f);
    logic [13:0] v;
    v = s;
    if (f[1:0] == FMT_OFFSET_BIN) v[13] = ~v[13];
    if (f[INVERT_BIT]) v = ~v;
    return {1'b0, v};
  endfunction : fx

  // Reset values, pattern bytes and an unmapped place.
  task automatic t_regs();
    rdc("format", IDX_FORMAT, 32'h01);
    rdc("stsel", IDX_STSEL, 32'h00);
    rdc("pat3lo", IDX_PAT3_LO, 32'h00);
    rdc("status", IDX_OR_STATUS, 32'h00);
    wr(IDX_PAT3_LO, 8'h33);
    wr(IDX_PAT3_HI, 8'hd3);
    wr(IDX_PAT4_LO, 8'h44);
    wr(IDX_PAT4_HI, 8'h24);
    rdc("pat3hi", IDX_PAT3_HI, 32'hd3);
    rdc("pat4lo", IDX_PAT4_LO, 32'h44);
    apb(1'b0, 11'h570, 32'h0, r, e);
    chk("unmapped err", 1, e);
  endtask : t_regs

  // Every format and invert combination.
  task automatic t_format();
    logic [2:0] f;
    for (int i = 0; i < 4; i++) begin
      f = {i[1], 1'b0, ~i[0]};
      wr(IDX_FORMAT, {5'h0, f});
      smp(14'h0005, 14'h2abc, fx(14'h0005, f), fx(14'h2abc, f));
    end
    wr(IDX_FORMAT, RST_FORMAT);
  endtask : t_format

  // Each status code picks its own source; code 0 ignores all of them.
  task automatic t_stsel();
    logic [4:0] src;
    for (int c = 0; c < 5; c++) begin
      src = (c == 0) ? 5'h1e : (5'h01 << c);
      ovr  <= {2{src[1]}};
      smon <= {2{src[2]}};
      fld  <= {2{src[3]}};
      vrm  <= {2{src[4]}};
      wr(IDX_STSEL, 8'(c));
      smp(14'h0011, 14'h0022, {c != 0, 14'h0011},
          {c != 0, 14'h0022});
    end
    wr(IDX_STSEL, RST_ZERO);
  endtask : t_stsel

  // Channel swap exchanges the two output words.
  task automatic t_swap();
    wr(IDX_CHAN_SEL, 8'h01);
    smp(14'h0123, 14'h0456, 15'h0456, 15'h0123);
    wr(IDX_CHAN_SEL, 8'h00);
    smp(14'h0123, 14'h0456, 15'h0123, 15'h0456);
  endtask : t_swap

  // Sticky flags, their clears, a read-only write and the interrupt.
  task automatic t_range();
    @(posedge pclk);
    range_evt <= 8'ha5;
    @(posedge pclk);
    range_evt <= 8'h00;
    rdc("status", IDX_OR_STATUS, 32'ha5);
    rdc("status held", IDX_OR_STATUS, 32'ha5);
    chk("irq masked", 0, irq);
    wr(IDX_OR_CLEAR, 8'h05);
    rdc("status clr", IDX_OR_STATUS, 32'ha0);
    wr(IDX_OR_CLEAR, 8'h00);
    @(posedge pclk);
    range_evt <= 8'h01;
    @(posedge pclk);
    range_evt <= 8'h00;
    wr(IDX_OR_STATUS, 8'hff);
    rdc("status ro", IDX_OR_STATUS, 32'ha1);
    wr(IDX_IRQ_MASK, 8'hff);
    repeat (2) @(posedge pclk);
    chk("irq on", 1, irq);
    wr(IDX_IRQ_STAT, 8'hff);
    repeat (2) @(posedge pclk);
    chk("irq off", 0, irq);
    rdc("irq stat", IDX_IRQ_STAT, 32'h00);
    // A fresh event with the mask open raises the interrupt again.
    @(posedge pclk);
    range_evt <= 8'h10;
    @(posedge pclk);
    range_evt <= 8'h00;
    @(posedge pclk);
    chk("irq event", 1, irq);
    rdc("irq stat set", IDX_IRQ_STAT, 32'h10);
    wr(IDX_IRQ_STAT, 8'h10);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 0, irq);
  endtask : t_range

  // User pattern through the sink, repeating or once.
  task automatic t_pat(input logic single);
    logic [14:0] ex[6];
    ex = '{15'h1111, 15'h2222, 15'h1333, 15'h2444,
           single ? 15'h0 : 15'h1111, single ? 15'h0 : 15'h2222};
    @(posedge pclk);
    test_mode_sel  <= 4'h0;
    pattern_single <= single;
    repeat (2) @(posedge pclk);
    test_mode_sel <= TEST_USER_PATTERN;
    repeat (2) @(posedge pclk);
    u_sink.qa.delete();
    u_sink.qb.delete();
    in_valid <= 1'b1;
    repeat (6) @(posedge pclk);
    in_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pattern count", 6, u_sink.qa.size());
    for (int i = 0; i < 6 && i < u_sink.qa.size(); i++) begin
      chk("pattern a", {17'h0, ex[i]}, {17'h0, u_sink.qa[i]});
      chk("pattern b", {17'h0, ex[i]}, {17'h0, u_sink.qb[i]});
    end
    test_mode_sel <= 4'h0;
  endtask : t_pat

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #200us;
    err_total++;
    results();
  end

  // Main sequence: reset for 12 edges, then each scenario in turn.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_format();
    t_stsel();
    t_swap();
    t_range();
    t_pat(1'b0);
    t_pat(1'b1);
    results();
  end
endmodule : fmt_status_regs_tb
